// ===== hdl/fhr_defines.svh
// offsets, bit positions, reset values and timing counts of the host registers
// assumes byte-wide host access with a 3-bit register offset
`ifndef FHR_DEFINES_SVH
`define FHR_DEFINES_SVH

// register offsets
`define FHR_OFF_MONITOR   3'h1
`define FHR_OFF_OUT_CTL   3'h2
`define FHR_OFF_TAPE      3'h3
`define FHR_OFF_RATE      3'h4
`define FHR_OFF_DATA      3'h5
`define FHR_OFF_SENSE     3'h7

// rate, alternate control and output control register fields
`define FHR_RATE_SWRST    7
`define FHR_RATE_PDOWN    6
`define FHR_RATE_SHIFT_HI 4
`define FHR_RATE_SHIFT_LO 2
`define FHR_ALT_NOSHIFT   2
`define FHR_OUT_XFER_EN   3

// reset values
`define FHR_RST_BYTE      8'h00
`define FHR_RST_RATE      2'h0
`define FHR_RST_SHIFT     3'h0

// write shift delay, in 41.67 ns steps
`define FHR_SHIFT_STEP_PS 41670
`define FHR_SHIFT_DEFAULT 3'h3
`define FHR_SHIFT_DEF_1M  3'h1
`define FHR_SHIFT_OFF     3'h7
`define FHR_RATE_1M       2'h3

`endif

// ===== hdl/fhr_pkg.sv
// types shared by the floppy host register bank
// assumes fhr_defines.svh carries the numeric constants
package fhr_pkg;

   // bit map presented by the monitor and input sense registers
   typedef enum logic [1:0] {
      FHR_BASIC,
      FHR_FULL,
      FHR_ALT
   } fhr_mode_t;

   typedef logic [7:0] fhr_byte_t;

endpackage

// ===== hdl/fhr_regs.sv
// host register bank of a floppy controller: monitor, output control,
// tape assignment, rate programming, data port and input sense
// assumes drive pins and configuration inputs are synchronous to clk
// Summary of operation
// - full mode monitor bit 5 returns output control drive select bit 0
// - full mode monitor bit 4 toggles on each write data rising edge
// - full mode monitor bit 3 toggles on each read pulse rising edge
// - full mode monitor bits 2..0 are inverted write gate, motor B, motor A
// - alternate mode bit 7 is second unit absent; bits 6,5 unit B,A selects
// - alternate mode bits 1,0 read 0 while unit D, C is selected
// - alternate mode bits 4..2 are inverted latched write data, read, gate
// - output control is write-only, cleared by the master reset pin
// - without three-mode, tape register holds only its two low bits
// - tape select 00 none, 01..11 units 1..3, never unit 0
// - three-mode tape bits 7:6, 3:2 mirror media boot config 3:2, 1:0
// - three-mode tape bits 5:4 give drive type of last selected unit
// - data rate comes from the latest rate or alternate control write
// - rate bit 7 fires a software reset; bit 6 selects power-down
// - rate bits 4:2 pick write shift delay, default or disabled
// - rate bits 1:0 pick data rate and reduced current output
// - data port shows one stacked register at a time to the host
// - data port FIFO disabled after reset, enabled only by setup
// - basic mode input sense drives only bit 7, inverted media change
// - full mode sense: bit 7 inverted, 6-3 ones, rate, low density
// - alternate sense: bit 7 plain, 6-4 ones, bit 3, no-shift, rate
`timescale 1ns/1ps
`include "fhr_defines.svh"
module fhr_regs
   import fhr_pkg::*;
(
   // clock, reset and freeze
   input  wire logic      clk,
   input  wire logic      sys_rst,
   input  wire logic      clk_en,
   input  wire logic      master_reset_pin,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire fhr_byte_t reg_wdata,
   input  wire logic      reg_wr,
   input  wire logic      reg_rd,
   output fhr_byte_t      reg_rdata,
   output fhr_byte_t      reg_rdata_oe,
   // static configuration
   input  wire fhr_mode_t compat_mode,
   input  wire logic      three_mode_enable,
   input  wire fhr_byte_t drive_type_config,
   input  wire logic [3:0] media_boot_config,
   // drive cable levels
   input  wire logic      write_data_out_n,
   input  wire logic      read_pulse_in_n,
   input  wire logic      write_gate_n,
   input  wire logic      motor_a_on_n,
   input  wire logic      motor_b_on_n,
   input  wire logic      unit_a_select_n,
   input  wire logic      unit_b_select_n,
   input  wire logic      unit_c_select_n,
   input  wire logic      unit_d_select_n,
   input  wire logic      second_unit_absent,
   input  wire logic      media_changed_n,
   // command engine side
   input  wire fhr_byte_t main_flow_status,
   input  wire fhr_byte_t data_port_byte,
   input  wire logic      setup_load,
   input  wire logic      setup_fifo_on,
   output fhr_byte_t      output_control,
   output logic [1:0]     tape_select,
   output logic [1:0]     rate_select,
   output logic [2:0]     write_shift_select,
   output logic [2:0]     shift_steps,
   output logic           no_shift_flag,
   output logic           reduced_current_n,
   output logic           power_down,
   output logic           soft_reset,
   output logic           fifo_enable,
   output logic           data_wr,
   output logic           data_rd,
   output fhr_byte_t      data_wdata
);

   fhr_byte_t  out_ctl_q, data_wdata_q, rdata_q, rdata_oe_q;
   fhr_byte_t  rdata_d, rdata_oe_d, monitor_full, monitor_alt, tape_view;
   logic [1:0] tape_sel_q, rate_q, last_unit_q, drive_type;
   logic [2:0] shift_sel_q, shift_step_q, shift_step_d;
   logic       wd_prev_q, rd_prev_q, wd_tog_q, rd_tog_q, wd_lat_q, rd_lat_q, we_lat_q;
   logic       no_shift_q, pdown_q, swrst_q, rwc_n_q, fifo_en_q, data_wr_q, data_rd_q;
   logic       wr_rate, wr_alt, wd_rise, rd_rise, low_density;

   assign wr_rate = clk_en && reg_wr && reg_addr == `FHR_OFF_RATE;
   assign wr_alt  = clk_en && reg_wr && reg_addr == `FHR_OFF_SENSE;
   assign wd_rise = write_data_out_n && !wd_prev_q;
   assign rd_rise = read_pulse_in_n && !rd_prev_q;

   // write-only control, master reset clears it
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         out_ctl_q <= `FHR_RST_BYTE;
      else if (clk_en && master_reset_pin)
         out_ctl_q <= `FHR_RST_BYTE;
      else if (clk_en && reg_wr && reg_addr == `FHR_OFF_OUT_CTL)
         out_ctl_q <= reg_wdata;
   end

   // the unit chosen last in output control steers the drive type view
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         last_unit_q <= 2'h0;
      else if (clk_en && reg_wr && reg_addr == `FHR_OFF_OUT_CTL)
         last_unit_q <= reg_wdata[1:0];
   end

   // only the two low bits are storage
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         tape_sel_q <= 2'h0;
      else if (clk_en && reg_wr && reg_addr == `FHR_OFF_TAPE)
         tape_sel_q <= reg_wdata[1:0];
   end

   // last writer of either register sets the rate
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rate_q <= `FHR_RST_RATE;
      else if (wr_rate || wr_alt)
         rate_q <= reg_wdata[1:0];
   end

   // power-down level and one-cycle software reset
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pdown_q     <= 1'b0;
         swrst_q     <= 1'b0;
         shift_sel_q <= `FHR_RST_SHIFT;
      end
      else if (clk_en)
      begin
         swrst_q <= wr_rate && reg_wdata[`FHR_RATE_SWRST];
         if (wr_rate)
         begin
            pdown_q     <= reg_wdata[`FHR_RATE_PDOWN];
            shift_sel_q <= reg_wdata[`FHR_RATE_SHIFT_HI:`FHR_RATE_SHIFT_LO];
         end
      end
   end

   // no-shift flag has no function beyond being read back
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         no_shift_q <= 1'b0;
      else if (wr_alt)
         no_shift_q <= reg_wdata[`FHR_ALT_NOSHIFT];
   end

   // effective shift delay in 41.67 ns steps, 0 when disabled
   always_comb
   begin
      case (shift_sel_q)
         3'h0:
            shift_step_d = (rate_q == `FHR_RATE_1M) ? `FHR_SHIFT_DEF_1M
                                                    : `FHR_SHIFT_DEFAULT;
         `FHR_SHIFT_OFF:
            shift_step_d = 3'h0;
         default:
            shift_step_d = shift_sel_q;
      endcase
   end

   // reduced current is released only at 500K and 1M
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rwc_n_q      <= 1'b1;
         shift_step_q <= `FHR_SHIFT_DEFAULT;
      end
      else if (clk_en)
      begin
         rwc_n_q      <= rate_q == 2'h0 || rate_q == 2'h3;
         shift_step_q <= shift_step_d;
      end
   end

   // FIFO starts disabled, only the setup command changes it
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         fifo_en_q <= 1'b0;
      else if (clk_en && setup_load)
         fifo_en_q <= setup_fifo_on;
   end

   // data port strobes pass to the stacked registers of the engine
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         data_wr_q    <= 1'b0;
         data_rd_q    <= 1'b0;
         data_wdata_q <= `FHR_RST_BYTE;
      end
      else if (clk_en)
      begin
         data_wr_q <= reg_wr && reg_addr == `FHR_OFF_DATA;
         data_rd_q <= reg_rd && reg_addr == `FHR_OFF_DATA;
         if (reg_wr && reg_addr == `FHR_OFF_DATA)
            data_wdata_q <= reg_wdata;
      end
   end

   // write data toggle; read pulse toggle
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wd_prev_q <= 1'b1;
         rd_prev_q <= 1'b1;
         wd_tog_q  <= 1'b0;
         rd_tog_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         wd_prev_q <= write_data_out_n;
         rd_prev_q <= read_pulse_in_n;
         if (wd_rise)
            wd_tog_q <= !wd_tog_q;
         if (rd_rise)
            rd_tog_q <= !rd_tog_q;
      end
   end

   // latches; write data is caught only at its rising edge
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wd_lat_q <= 1'b0;
         rd_lat_q <= 1'b1;
         we_lat_q <= 1'b1;
      end
      else if (clk_en)
      begin
         if (wd_rise)
            wd_lat_q <= write_data_out_n;
         rd_lat_q <= read_pulse_in_n;
         we_lat_q <= write_gate_n;
      end
   end

   // drive type pair of the unit selected last
   always_comb
   begin
      case (last_unit_q)
         2'h0:    drive_type = drive_type_config[1:0];
         2'h1:    drive_type = drive_type_config[3:2];
         2'h2:    drive_type = drive_type_config[5:4];
         default: drive_type = drive_type_config[7:6];
      endcase
   end

   // low density at 250K and 300K
   assign low_density = rate_q == 2'h1 || rate_q == 2'h2;

   // bit 5; inverted pin levels in bits 2..0
   assign monitor_full = {2'h3, out_ctl_q[0], wd_tog_q, rd_tog_q,
                          !write_gate_n, !motor_b_on_n, !motor_a_on_n};
   // bits 7..5; unit selects in bits 1,0
   assign monitor_alt  = {second_unit_absent, unit_b_select_n,
                          unit_a_select_n, !wd_lat_q, !rd_lat_q,
                          !we_lat_q, unit_d_select_n, unit_c_select_n};
   // select code passes as written; media boot mirrors
   assign tape_view    = three_mode_enable
                         ? {media_boot_config[3:2], drive_type,
                            media_boot_config[1:0], tape_sel_q}
                         : {6'h00, tape_sel_q};

   // read map chosen by the static mode input
   always_comb
   begin
      rdata_d    = `FHR_RST_BYTE;
      rdata_oe_d = 8'hff;
      case (reg_addr)
         `FHR_OFF_MONITOR:
            if (compat_mode == FHR_FULL)
               rdata_d = monitor_full;
            else if (compat_mode == FHR_ALT)
               rdata_d = monitor_alt;
         `FHR_OFF_TAPE:
            rdata_d = tape_view;
         `FHR_OFF_RATE:
            rdata_d = main_flow_status;
         `FHR_OFF_DATA:
            rdata_d = data_port_byte;
         `FHR_OFF_SENSE:
            if (compat_mode == FHR_FULL)
               rdata_d = {!media_changed_n, 4'hf, rate_q, low_density};
            else if (compat_mode == FHR_ALT)
               rdata_d = {media_changed_n, 3'h7, out_ctl_q[`FHR_OUT_XFER_EN],
                          no_shift_q, rate_q};
            else
            begin
               // only bit 7 is driven, rest left floating
               rdata_d    = {!media_changed_n, 7'h00};
               rdata_oe_d = 8'h80;
            end
         default:
            rdata_d = `FHR_RST_BYTE;
      endcase
   end

   // read data stand for one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_q    <= `FHR_RST_BYTE;
         rdata_oe_q <= `FHR_RST_BYTE;
      end
      else if (clk_en)
      begin
         rdata_q    <= reg_rd ? rdata_d : `FHR_RST_BYTE;
         rdata_oe_q <= reg_rd ? rdata_oe_d : `FHR_RST_BYTE;
      end
   end

   assign reg_rdata          = rdata_q;
   assign reg_rdata_oe       = rdata_oe_q;
   assign output_control     = out_ctl_q;
   assign tape_select        = tape_sel_q;
   assign rate_select        = rate_q;
   assign write_shift_select = shift_sel_q;
   assign shift_steps        = shift_step_q;
   assign no_shift_flag      = no_shift_q;
   assign reduced_current_n  = rwc_n_q;
   assign power_down         = pdown_q;
   assign soft_reset         = swrst_q;
   assign fifo_enable        = fifo_en_q;
   assign data_wr            = data_wr_q;
   assign data_rd            = data_rd_q;
   assign data_wdata         = data_wdata_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_out_ctl_clear:
   assert property (clk_en && master_reset_pin |=> out_ctl_q == 8'h00)
      else $error("output control not cleared by master reset");
   chk_wd_toggle_flip:
   assert property (clk_en && wd_rise |=> wd_tog_q != $past(wd_tog_q))
      else $error("write data toggle missed an edge");
   chk_rd_toggle_hold:
   assert property (clk_en && !rd_rise |=> rd_tog_q == $past(rd_tog_q))
      else $error("read toggle moved without an edge");
   chk_monitor_sel0:
   assert property (clk_en && reg_rd && reg_addr == 3'h1 && compat_mode == FHR_FULL
                    |=> reg_rdata[5] == $past(out_ctl_q[0]))
      else $error("monitor bit 5 differs from drive select 0");
   chk_rwc_from_write:
   assert property (clk_en && reg_wr && reg_addr == 3'h4 && reg_wdata[1:0] == 2'h1
                    ##1 clk_en |=> !reduced_current_n)
      else $error("reduced current not asserted at 300K");
   // a frozen cycle or a second reset write may legally stretch the pulse
   chk_soft_reset_pulse:
   assert property (clk_en && reg_wr && reg_addr == 3'h4 && reg_wdata[7]
                    |=> soft_reset ##1 (!soft_reset || !$past(clk_en)
                                        || ($past(wr_rate) && $past(reg_wdata[7]))))
      else $error("software reset not a single pulse");
   chk_basic_sense_oe:
   assert property (clk_en && reg_rd && reg_addr == 3'h7 && compat_mode == FHR_BASIC
                    |=> reg_rdata_oe == 8'h80 && reg_rdata[6:0] == 7'h00)
      else $error("basic sense read drives more than bit 7");
   chk_fifo_only_setup:
   assert property (!(clk_en && setup_load) |=> fifo_enable == $past(fifo_enable))
      else $error("fifo enable changed without setup");
   chk_tape_narrow:
   assert property (clk_en && reg_rd && reg_addr == 3'h3 && !three_mode_enable
                    |=> reg_rdata[7:2] == 6'h00)
      else $error("tape register shows upper bits");
   chk_rate_latest:
   assert property (clk_en && reg_wr && (reg_addr == 3'h7 || reg_addr == 3'h4)
                    |=> rate_select == $past(reg_wdata[1:0]))
      else $error("rate not taken from latest write");
   chk_shift_disabled:
   assert property (clk_en && shift_sel_q == 3'h7 |=> shift_steps == 3'h0)
      else $error("disabled shift delay not zero");

endmodule // fhr_regs

// ===== tb/fhr_drive_model.sv
// drive cable model: gives write data and read pulses to the register bank
// assumes requests are one-cycle pulses launched right after a clock edge
`timescale 1ns/1ps
module fhr_drive_model
(
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // pulse requests from the bench
   input  wire logic wd_req,
   input  wire logic rd_req,
   // cable lines, idle high
   output logic      write_data_out_n,
   output logic      read_pulse_in_n
);
   // each request gives one low cycle, so one rising edge follows it
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         write_data_out_n <= 1'b1;
         read_pulse_in_n  <= 1'b1;
      end
      else
      begin
         write_data_out_n <= ~wd_req;
         read_pulse_in_n  <= ~rd_req;
      end
   end
endmodule // fhr_drive_model

// ===== tb/testbench.sv
// self-checking bench of the floppy host register bank
// assumes a single 20 MHz clock and the drive cable model beside it
`timescale 1ns/1ps
`include "fhr_defines.svh"
module testbench
   import fhr_pkg::*;
;
   logic       clk, sys_rst, clk_en, master_reset_pin, reg_wr, reg_rd;
   logic       three_mode_enable, write_gate_n, motor_a_on_n, motor_b_on_n;
   logic       unit_a_select_n, unit_b_select_n, unit_c_select_n, unit_d_select_n;
   logic       second_unit_absent, media_changed_n, setup_load, setup_fifo_on;
   logic       wd_req, rd_req, write_data_out_n, read_pulse_in_n;
   logic [2:0] reg_addr, write_shift_select, shift_steps;
   logic [3:0] media_boot_config;
   logic [1:0] tape_select, rate_select;
   logic       no_shift_flag, reduced_current_n, power_down, soft_reset;
   logic       fifo_enable, data_wr, data_rd;
   fhr_byte_t  reg_wdata, drive_type_config, main_flow_status, data_port_byte;
   fhr_byte_t  reg_rdata, reg_rdata_oe, output_control, data_wdata, d, oe;
   fhr_mode_t  compat_mode;
   int         miscompares, checked, cycles;

   fhr_regs u_fhr_regs (.clk, .sys_rst, .clk_en, .master_reset_pin, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rdata_oe, .compat_mode,
      .three_mode_enable, .drive_type_config, .media_boot_config,
      .write_data_out_n, .read_pulse_in_n, .write_gate_n, .motor_a_on_n,
      .motor_b_on_n, .unit_a_select_n, .unit_b_select_n, .unit_c_select_n,
      .unit_d_select_n, .second_unit_absent, .media_changed_n,
      .main_flow_status, .data_port_byte, .setup_load, .setup_fifo_on,
      .output_control, .tape_select, .rate_select, .write_shift_select,
      .shift_steps, .no_shift_flag, .reduced_current_n, .power_down,
      .soft_reset, .fifo_enable, .data_wr, .data_rd, .data_wdata);

   fhr_drive_model u_fhr_drive_model (.clk, .sys_rst, .wd_req, .rd_req,
      .write_data_out_n, .read_pulse_in_n);

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic finish_test();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // a hung handshake would otherwise run forever
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         finish_test();
      end
   end

   task automatic cmp(input fhr_byte_t g, input fhr_byte_t e);
      checked++;
      if (g !== e)
      begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
         miscompares++;
      end
   endtask

   task automatic wr(input logic [2:0] a, input fhr_byte_t v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      @(negedge clk);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      d  = reg_rdata;
      oe = reg_rdata_oe;
   endtask

   task automatic chk_rd(input logic [2:0] a, input fhr_byte_t e);
      rd(a);
      cmp(d, e);
   endtask

   task automatic pulse(input logic w);
      @(posedge clk);
      if (w)
         wd_req <= 1'b1;
      else
         rd_req <= 1'b1;
      @(posedge clk);
      wd_req <= 1'b0;
      rd_req <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic t_reset();
      @(negedge clk);
      cmp(output_control, 8'h00);
      cmp({7'h00, reduced_current_n}, 8'h01);
      cmp({5'h00, shift_steps}, 8'h03);
      cmp({7'h00, fifo_enable}, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_full();
      @(posedge clk);
      compat_mode <= FHR_FULL;
      wr(`FHR_OFF_OUT_CTL, 8'h01);
      chk_rd(`FHR_OFF_MONITOR, 8'he5);
      pulse(1'b1);
      pulse(1'b0);
      chk_rd(`FHR_OFF_MONITOR, 8'hfd);
      pulse(1'b0);
      chk_rd(`FHR_OFF_MONITOR, 8'hf5);
      @(posedge clk);
      write_gate_n <= 1'b1;
      motor_b_on_n <= 1'b0;
      chk_rd(`FHR_OFF_MONITOR, 8'hf3);
      @(posedge clk);
      write_gate_n <= 1'b0;
      motor_b_on_n <= 1'b1;
      $display("test full monitor done");
   endtask

   task automatic t_alt();
      @(posedge clk);
      compat_mode <= FHR_ALT;
      chk_rd(`FHR_OFF_MONITOR, 8'ha6);
      @(posedge clk);
      second_unit_absent <= 1'b0;
      unit_c_select_n    <= 1'b1;
      unit_d_select_n    <= 1'b0;
      chk_rd(`FHR_OFF_MONITOR, 8'h25);
      @(posedge clk);
      write_gate_n <= 1'b1;
      chk_rd(`FHR_OFF_MONITOR, 8'h21);
      @(posedge clk);
      write_gate_n <= 1'b0;
      $display("test alt monitor done");
   endtask

   task automatic t_ctl();
      cmp(output_control, 8'h01);
      @(posedge clk);
      master_reset_pin <= 1'b1;
      @(posedge clk);
      master_reset_pin <= 1'b0;
      @(negedge clk);
      cmp(output_control, 8'h00);
      $display("test output control done");
   endtask

   task automatic t_tape();
      for (int i = 0; i < 4; i++)
      begin
         wr(`FHR_OFF_TAPE, 8'hfc | i[7:0]);
         cmp({6'h00, tape_select}, i[7:0]);
         chk_rd(`FHR_OFF_TAPE, i[7:0]);
      end
      @(posedge clk);
      three_mode_enable <= 1'b1;
      wr(`FHR_OFF_OUT_CTL, 8'h02);
      wr(`FHR_OFF_TAPE, 8'h01);
      chk_rd(`FHR_OFF_TAPE, 8'ha5);
      wr(`FHR_OFF_OUT_CTL, 8'h03);
      chk_rd(`FHR_OFF_TAPE, 8'hb5);
      $display("test tape done");
   endtask

   task automatic t_rate();
      for (int r = 0; r < 4; r++)
      begin
         wr(`FHR_OFF_RATE, r[7:0]);
         cmp({6'h00, rate_select}, r[7:0]);
         @(negedge clk);
         cmp({7'h00, reduced_current_n}, (r == 0 || r == 3) ? 8'h01 : 8'h00);
         cmp({5'h00, shift_steps}, (r == 3) ? 8'h01 : 8'h03);
      end
      for (int s = 1; s < 8; s++)
      begin
         wr(`FHR_OFF_RATE, 8'h40 | (s[7:0] << 2));
         cmp({5'h00, write_shift_select}, s[7:0]);
         cmp({7'h00, power_down}, 8'h01);
         @(negedge clk);
         cmp({5'h00, shift_steps}, (s == 7) ? 8'h00 : s[7:0]);
      end
      wr(`FHR_OFF_RATE, 8'h80);
      cmp({6'h00, soft_reset, power_down}, 8'h02);
      @(negedge clk);
      cmp({7'h00, soft_reset}, 8'h00);
      wr(`FHR_OFF_SENSE, 8'h03);
      cmp({6'h00, rate_select}, 8'h03);
      wr(`FHR_OFF_RATE, 8'h01);
      cmp({6'h00, rate_select}, 8'h01);
      $display("test rate done");
   endtask

   task automatic t_sense();
      @(posedge clk);
      compat_mode <= FHR_BASIC;
      rd(`FHR_OFF_SENSE);
      cmp(oe, 8'h80);
      cmp(d & oe, 8'h80);
      @(posedge clk);
      compat_mode <= FHR_FULL;
      chk_rd(`FHR_OFF_SENSE, 8'hfb);
      cmp(oe, 8'hff);
      @(posedge clk);
      compat_mode <= FHR_ALT;
      wr(`FHR_OFF_OUT_CTL, 8'h08);
      wr(`FHR_OFF_SENSE, 8'h06);
      cmp({7'h00, no_shift_flag}, 8'h01);
      chk_rd(`FHR_OFF_SENSE, 8'h7e);
      $display("test sense done");
   endtask

   task automatic t_data();
      wr(`FHR_OFF_DATA, 8'h5a);
      cmp({7'h00, data_wr}, 8'h01);
      cmp(data_wdata, 8'h5a);
      chk_rd(`FHR_OFF_DATA, 8'h3c);
      cmp({7'h00, data_rd}, 8'h01);
      chk_rd(`FHR_OFF_RATE, 8'hc3);
      chk_rd(3'h6, 8'h00);
      cmp(oe, 8'hff);
      // a strobe in a frozen cycle must be dropped
      @(posedge clk);
      clk_en <= 1'b0;
      wr(`FHR_OFF_DATA, 8'h11);
      cmp({7'h00, data_wr}, 8'h00);
      cmp(data_wdata, 8'h5a);
      @(posedge clk);
      clk_en     <= 1'b1;
      setup_load <= 1'b1;
      @(posedge clk);
      setup_load <= 1'b0;
      @(negedge clk);
      cmp({7'h00, fifo_enable}, 8'h01);
      $display("test data port done");
   endtask

   initial
   begin
      sys_rst = 1'b1; clk_en = 1'b1; master_reset_pin = 1'b0;
      reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
      compat_mode = FHR_BASIC; three_mode_enable = 1'b0;
      drive_type_config = 8'he4; media_boot_config = 4'h9;
      write_gate_n = 1'b0; motor_a_on_n = 1'b0; motor_b_on_n = 1'b1;
      unit_a_select_n = 1'b1; unit_b_select_n = 1'b0;
      unit_c_select_n = 1'b0; unit_d_select_n = 1'b1;
      second_unit_absent = 1'b1; media_changed_n = 1'b0;
      main_flow_status = 8'hc3; data_port_byte = 8'h3c;
      setup_load = 1'b0; setup_fifo_on = 1'b1; wd_req = 1'b0; rd_req = 1'b0;
      miscompares = 0; checked = 0; cycles = 0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_full();
      t_alt();
      t_ctl();
      t_tape();
      t_rate();
      t_sense();
      t_data();
      finish_test();
   end
endmodule // testbench
